// File: include/actr_consts.vh
`ifndef ACTR_CONSTS_VH
`define ACTR_CONSTS_VH

// Register addresses (byte addresses of the serial register port)
`define ACTR_ADDR_TA_SGL_INB 15'h0_31A
`define ACTR_ADDR_TB_SGL_INB 15'h0_31B
`define ACTR_ADDR_OA_DUAL_INA 15'h0_344
`define ACTR_ADDR_OA_DUAL_INB 15'h0_346
`define ACTR_ADDR_OA_SGL_INA 15'h0_348
`define ACTR_ADDR_OA_SGL_INB 15'h0_34A

// Printed reset values; fuse defaults replace them one cycle after reset
`define ACTR_RST_TIMING 8'h00
`define ACTR_RST_OFFSET 16'h0000

// Field layout of the offset registers
`define ACTR_OFS_MSB 11
`define ACTR_RSV_MSB 15
`define ACTR_RSV_LSB 12

// Index of each trim in the fuse image
`define ACTR_FUSE_TA 3'h0
`define ACTR_FUSE_TB 3'h1
`define ACTR_FUSE_O0 3'h2
`define ACTR_FUSE_O1 3'h3
`define ACTR_FUSE_O2 3'h4
`define ACTR_FUSE_O3 3'h5

`endif

// File: hw/actr_trim_select.v
`timescale 1ns/100ps
`include "actr_consts.vh"

module actr_trim_select (
  // Operating mode
  input  wire        single_mode,
  input  wire        sample_input_two,
  input  wire        fg_cal_enable,
  // Stored trims
  input  wire [7:0]  core_a_single_inb_timing_trim,
  input  wire [7:0]  core_b_single_inb_timing_trim,
  input  wire [11:0] core_a_dual_ina_offset_trim,
  input  wire [11:0] core_a_dual_inb_offset_trim,
  input  wire [11:0] core_a_single_ina_offset_trim,
  input  wire [11:0] core_a_single_inb_offset_trim,
  // Selected trims
  output reg  [7:0]  core_a_timing,
  output reg         core_a_timing_valid,
  output reg  [7:0]  core_b_timing,
  output reg         core_b_timing_valid,
  output reg  [11:0] core_a_offset,
  output reg         core_a_offset_valid
);

  always @* begin
    core_a_timing       = 8'h00;
    core_a_timing_valid = 1'b0;
    core_b_timing       = 8'h00;
    core_b_timing_valid = 1'b0;
    core_a_offset       = 12'h000;
    core_a_offset_valid = 1'b0;
    if (fg_cal_enable) begin
      if (single_mode && sample_input_two) begin
        core_a_timing       = core_a_single_inb_timing_trim;
        core_a_timing_valid = 1'b1;
        core_b_timing       = core_b_single_inb_timing_trim;
        core_b_timing_valid = 1'b1;
      end
      core_a_offset_valid = 1'b1;
      if (!single_mode && !sample_input_two) begin
        core_a_offset = core_a_dual_ina_offset_trim;
      end else if (!single_mode) begin
        core_a_offset = core_a_dual_inb_offset_trim;
      end else if (!sample_input_two) begin
        core_a_offset = core_a_single_ina_offset_trim;
      end else begin
        core_a_offset = core_a_single_inb_offset_trim;
      end
    end
  end

endmodule

// File: hw/actr_trim_bank.v
// Summary of operation
// - 8-bit RW core A timing trim, used single mode, calibration on, input two.
// - 8-bit RW core B timing trim, used single mode, calibration on, input two.
// - 12-bit core A offset trim for dual mode, input one, calibration on.
// - 12-bit core A offset trim for dual mode, input two, calibration on.
// - 12-bit core A offset trim for single mode, input one, calibration on.
// - 12-bit core A offset trim for single mode, input two, calibration on.
// - Reset loads zero, then fuse values one cycle later; offset bits 15:12 are reserved.
// - Software can read back factory trims and overwrite them.
`timescale 1ns/100ps
`include "actr_consts.vh"

module actr_trim_bank (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [14:0] reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  // Factory fuse image, six 16-bit words
  input  wire [95:0] fuse_image,
  // Operating mode
  input  wire        single_mode,
  input  wire        sample_input_two,
  input  wire        fg_cal_enable,
  // Trims delivered to the cores
  output wire [7:0]  core_a_timing,
  output wire        core_a_timing_valid,
  output wire [7:0]  core_b_timing,
  output wire        core_b_timing_valid,
  output wire [11:0] core_a_offset,
  output wire        core_a_offset_valid
);

  reg [7:0]  core_a_single_inb_timing_trim;
  reg [7:0]  core_b_single_inb_timing_trim;
  reg [15:0] core_a_dual_ina_offset_trim;
  reg [15:0] core_a_dual_inb_offset_trim;
  reg [15:0] core_a_single_ina_offset_trim;
  reg [15:0] core_a_single_inb_offset_trim;
  reg        fuse_pending;
  reg [15:0] next_rdata;

  function [15:0] fuse_word;
    input [95:0] image;
    input [2:0]  idx;
    begin
      fuse_word = image[idx*16 +: 16];
    end
  endfunction

  // Timing trims keep only the low byte of their fuse word
  function [7:0] fuse_byte;
    input [95:0] image;
    input [2:0]  idx;
    begin
      fuse_byte = image[idx*16 +: 8];
    end
  endfunction

  // Fuse load one cycle after reset so no port value enters the reset path
  always @(posedge clock) begin
    if (rst) begin
      fuse_pending                  <= 1'b1;
      core_a_single_inb_timing_trim <= `ACTR_RST_TIMING;
      core_b_single_inb_timing_trim <= `ACTR_RST_TIMING;
      core_a_dual_ina_offset_trim   <= `ACTR_RST_OFFSET;
      core_a_dual_inb_offset_trim   <= `ACTR_RST_OFFSET;
      core_a_single_ina_offset_trim <= `ACTR_RST_OFFSET;
      core_a_single_inb_offset_trim <= `ACTR_RST_OFFSET;
    end else if (fuse_pending) begin
      fuse_pending                  <= 1'b0;
      core_a_single_inb_timing_trim <= fuse_byte(fuse_image, `ACTR_FUSE_TA);
      core_b_single_inb_timing_trim <= fuse_byte(fuse_image, `ACTR_FUSE_TB);
      core_a_dual_ina_offset_trim   <= fuse_word(fuse_image, `ACTR_FUSE_O0);
      core_a_dual_inb_offset_trim   <= fuse_word(fuse_image, `ACTR_FUSE_O1);
      core_a_single_ina_offset_trim <= fuse_word(fuse_image, `ACTR_FUSE_O2);
      core_a_single_inb_offset_trim <= fuse_word(fuse_image, `ACTR_FUSE_O3);
    end else if (reg_wr) begin
      // Software overwrite of the factory trims
      if (reg_addr == `ACTR_ADDR_TA_SGL_INB) begin
        core_a_single_inb_timing_trim <= reg_wdata[7:0];
      end else if (reg_addr == `ACTR_ADDR_TB_SGL_INB) begin
        core_b_single_inb_timing_trim <= reg_wdata[7:0];
      end else if (reg_addr == `ACTR_ADDR_OA_DUAL_INA) begin
        core_a_dual_ina_offset_trim <= reg_wdata;
      end else if (reg_addr == `ACTR_ADDR_OA_DUAL_INB) begin
        core_a_dual_inb_offset_trim <= reg_wdata;
      end else if (reg_addr == `ACTR_ADDR_OA_SGL_INA) begin
        core_a_single_ina_offset_trim <= reg_wdata;
      end else if (reg_addr == `ACTR_ADDR_OA_SGL_INB) begin
        core_a_single_inb_offset_trim <= reg_wdata;
      end
    end
  end

  // Reserved bits are plain storage and read back as written
  always @* begin
    if (reg_addr == `ACTR_ADDR_TA_SGL_INB) begin
      next_rdata = {8'h00, core_a_single_inb_timing_trim};
    end else if (reg_addr == `ACTR_ADDR_TB_SGL_INB) begin
      next_rdata = {8'h00, core_b_single_inb_timing_trim};
    end else if (reg_addr == `ACTR_ADDR_OA_DUAL_INA) begin
      next_rdata = core_a_dual_ina_offset_trim;
    end else if (reg_addr == `ACTR_ADDR_OA_DUAL_INB) begin
      next_rdata = core_a_dual_inb_offset_trim;
    end else if (reg_addr == `ACTR_ADDR_OA_SGL_INA) begin
      next_rdata = core_a_single_ina_offset_trim;
    end else if (reg_addr == `ACTR_ADDR_OA_SGL_INB) begin
      next_rdata = core_a_single_inb_offset_trim;
    end else begin
      next_rdata = 16'h0000;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Only the 12-bit field reaches the core; bits 15:12 stay reserved
  actr_trim_select u_select (
    .single_mode                   (single_mode),
    .sample_input_two              (sample_input_two),
    .fg_cal_enable                 (fg_cal_enable),
    .core_a_single_inb_timing_trim (core_a_single_inb_timing_trim),
    .core_b_single_inb_timing_trim (core_b_single_inb_timing_trim),
    .core_a_dual_ina_offset_trim   (core_a_dual_ina_offset_trim[`ACTR_OFS_MSB:0]),
    .core_a_dual_inb_offset_trim   (core_a_dual_inb_offset_trim[`ACTR_OFS_MSB:0]),
    .core_a_single_ina_offset_trim (core_a_single_ina_offset_trim[`ACTR_OFS_MSB:0]),
    .core_a_single_inb_offset_trim (core_a_single_inb_offset_trim[`ACTR_OFS_MSB:0]),
    .core_a_timing                 (core_a_timing),
    .core_a_timing_valid           (core_a_timing_valid),
    .core_b_timing                 (core_b_timing),
    .core_b_timing_valid           (core_b_timing_valid),
    .core_a_offset                 (core_a_offset),
    .core_a_offset_valid           (core_a_offset_valid)
  );

endmodule

// File: bench/actr_trim_bank_asserts.sv
`timescale 1ns/100ps
module actr_trim_bank_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [14:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  // Mode
  input wire logic        single_mode,
  input wire logic        sample_input_two,
  input wire logic        fg_cal_enable,
  // Trims to cores
  input wire logic [7:0]  core_a_timing,
  input wire logic        core_a_timing_valid,
  input wire logic [7:0]  core_b_timing,
  input wire logic        core_b_timing_valid,
  input wire logic [11:0] core_a_offset,
  input wire logic        core_a_offset_valid
);
  default clocking dcb @(posedge clock); endclocking
  default disable iff (rst);
  wire sel_t = fg_cal_enable && single_mode && sample_input_two;
  timing_a_sel_a: assert property (core_a_timing_valid == sel_t)
    else $error("core a timing select");
  timing_b_sel_a: assert property (core_b_timing_valid == sel_t && (sel_t || !core_b_timing))
    else $error("core b timing select");
  offset_sel_a: assert property (core_a_offset_valid == fg_cal_enable)
    else $error("offset select");
  offset_apply_a: assert property ((reg_wr && reg_addr == 15'h0344 && !$past(rst)) |=>
    (!(fg_cal_enable && !single_mode && !sample_input_two)
     || {4'h0, core_a_offset} == ($past(reg_wdata) & 16'h0fff))) else $error("offset apply");
  timing_apply_a: assert property ((reg_wr && reg_addr == 15'h031a && !$past(rst)) |=>
    (!sel_t || {8'h00, core_a_timing} == ($past(reg_wdata) & 16'h00ff))) else $error("timing apply");
  read_valid_a: assert property (!$past(rst) |=> reg_rvalid == $past(reg_rd))
    else $error("read valid timing");
  unmapped_read_a: assert property ((reg_rd && reg_addr[14:10] && !$past(rst)) |=> !reg_rdata)
    else $error("unmapped read");
  write_read_a: assert property ((reg_wr && reg_addr == 15'h0344 && !$past(rst)) ##1 !reg_wr
    ##1 (reg_rd && !reg_wr && reg_addr == 15'h0344) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("write read back");
endmodule

// File: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clock, rst, reg_wr, reg_rd, reg_rvalid;
  logic        single_mode, sample_input_two, fg_cal_enable;
  logic        core_a_timing_valid, core_b_timing_valid, core_a_offset_valid;
  logic [7:0]  core_a_timing, core_b_timing;
  logic [11:0] core_a_offset;
  logic [14:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, o;
  logic [95:0] fuse_image;
  logic [15:0] sh [0:6];
  logic [15:0] q [$];
  logic [14:0] ad [0:6] = '{15'h031a, 15'h031b, 15'h0344, 15'h0346, 15'h0348, 15'h034a, 15'h0700};
  integer      seed, err_total, cmp_count, i, m;

  actr_trim_bank DUT (.*);
  always #10 clock = ~clock;

  // Timing trims read back as eight bits; the unmapped slot reads zero
  function automatic logic [15:0] fit(integer k, logic [15:0] d);
    fit = (k < 2) ? {8'h00, d[7:0]} : (k == 6) ? 16'h0000 : d;
  endfunction
  task chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(integer k, logic [15:0] d, bit r);
    @(posedge clock);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {1'b1, r, ad[k], d};
    if (r) q.push_back(sh[k]);
    sh[k] = fit(k, d);
    @(posedge clock);
    {reg_wr, reg_rd} <= 2'b00;
  endtask
  task rd(integer k);
    @(posedge clock);
    {reg_rd, reg_addr} <= {1'b1, ad[k]};
    q.push_back(sh[k]);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task md(integer v);
    @(posedge clock);
    {single_mode, sample_input_two, fg_cal_enable} <= v[2:0];
    @(negedge clock);
    o = sh[2 + v[2:1]];
    chk("a_tv", core_a_timing_valid, v == 7);
    chk("a_t", core_a_timing, v == 7 ? sh[0] : 16'h0000);
    chk("b_tv", core_b_timing_valid, v == 7);
    chk("b_t", core_b_timing, v == 7 ? sh[1] : 16'h0000);
    chk("a_ov", core_a_offset_valid, v[0]);
    chk("a_o", core_a_offset, v[0] ? o[11:0] : 12'h000);
  endtask
  always @(posedge clock)
    if (reg_rvalid === 1'b1) chk("rdata", reg_rdata, q.size() ? q.pop_front() : 16'hdead);
  task wrap_up;
    chk("pending", q.size(), 0);
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    wrap_up;
  end
  initial begin
    seed = 32'hac95_1aa6;
    err_total = 0;
    cmp_count = 0;
    clock = 0;
    rst = 1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {single_mode, sample_input_two, fg_cal_enable} = 3'b000;
    fuse_image = {$random(seed), $random(seed), $random(seed)};
    for (i = 0; i < 6; i++) sh[i] = fit(i, fuse_image[16*i +: 16]);
    sh[6] = 16'h0000;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 7; i++) rd(i);
    for (m = 0; m < 8; m++) md(m);
    md(1);
    for (i = 0; i < 7; i++) begin
      wr(i, $random(seed), 0);
      rd(i);
    end
    md(7);
    for (i = 0; i < 7; i++) wr(i, $random(seed), 1);
    for (m = 0; m < 8; m++) md(m);
    // Mid-run reset must reload a fresh fuse image over the written trims
    fuse_image <= {$random(seed), $random(seed), $random(seed)};
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    for (i = 0; i < 6; i++) sh[i] = fit(i, fuse_image[16*i +: 16]);
    rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 7; i++) rd(i);
    repeat (3) @(posedge clock);
    wrap_up;
  end
endmodule

bind actr_trim_bank actr_trim_bank_asserts u_chk (.*);
